// >>> adcsq_ctrl.v
// Summary of operation
// - busy set on start, cleared at end
// - busy write zero forces stop
// - single clears busy; others need stop
// - result store sets done, raises request
// - done cleared by zero write or service
// - interrupt enable gates request, resets zero
// - wait for transfer before storing result
// - two-bit field selects start sources
// - first enabled source starts, change immediate
// - pin falling edge, timer rising edge
// - start bit write one activates conversion
// - mode field: retrigger, single, continuous, stop
// - single mode converts start..end once
// - continuous and stop modes wrap back
// - stop mode pauses after each channel
// - three-bit channel fields, reset zero
// - start field reads current channel while busy
// - start above end wraps past seven
// - sampling time 64 or 4096 cycles
// - compare time 176 or 352 cycles
// - result updated on each conversion
`timescale 1ns/10ps
`include "adcsq_defines.vh"

module adcsq_ctrl
#(
	parameter ADDR_W = 8
)
(
	input  wire              i_clk_sys,
	input  wire              i_nrst,
	input  wire [ADDR_W-1:0] i_avs_address,
	input  wire              i_avs_read,
	input  wire              i_avs_write,
	input  wire [31:0]       i_avs_writedata,
	input  wire [3:0]        i_avs_byteenable,
	output reg  [31:0]       o_avs_readdata,
	output reg               o_avs_waitrequest,
	input  wire              i_ext_trig_n,
	input  wire              i_timer_trig,
	input  wire              i_xfer_enable,
	input  wire              i_xfer_clear,
	input  wire [9:0]        i_conv_data,
	output reg  [2:0]        o_chan_sel,
	output reg               o_sample,
	output reg               o_compare,
	output reg               o_busy,
	output reg               o_conv_irq
);

	// ********************************
	// states
	// ********************************
	localparam [4:0] ST_IDLE  = 5'h01;
	localparam [4:0] ST_SMP   = 5'h02;
	localparam [4:0] ST_CMP   = 5'h04;
	localparam [4:0] ST_XWAIT = 5'h08;
	localparam [4:0] ST_STOPW = 5'h10;

	// ********************************
	// functions
	// ********************************
	function [12:0] smp_len;
		input [1:0] code;
		begin
			if (code == 2'h3)
				smp_len = `ADCSQ_SMP_LONG;
			else
				smp_len = `ADCSQ_SMP_SHORT;
		end
	endfunction

	function [12:0] cmp_len;
		input [1:0] code;
		begin
			if (code == 2'h0)
				cmp_len = `ADCSQ_CMP_SHORT;
			else
				cmp_len = `ADCSQ_CMP_LONG;
		end
	endfunction

	function [2:0] next_chan;
		input [2:0] cur;
		input [2:0] last;
		input [2:0] first;
		begin
			if (cur == last)
				next_chan = first;
			else
				next_chan = cur + 3'h1;
		end
	endfunction

	// ********************************
	// registers
	// ********************************
	reg  [4:0]  state_q;
	reg  [4:0]  state_d;
	reg  [12:0] cnt_q;
	reg  [12:0] cnt_d;
	reg  [2:0]  cur_q;
	reg  [2:0]  cur_d;
	reg         busy_q;
	reg         busy_d;
	reg         done_q;
	reg         done_d;
	reg         conv_irq_enable_q;
	reg  [1:0]  trg_q;
	reg         test_q;
	reg  [1:0]  mode_q;
	reg  [2:0]  first_q;
	reg  [2:0]  last_q;
	reg  [1:0]  smp_q;
	reg  [1:0]  cmp_q;
	reg  [9:0]  result_q;
	reg  [9:0]  result_d;
	reg         ext_q;
	reg         tmr_q;
	reg  [7:0]  rd_byte;
	reg         store;

	// ********************************
	// bus decode
	// ********************************
	wire        req   = i_avs_read | i_avs_write;
	wire        wr_go = i_avs_write & ~o_avs_waitrequest & i_avs_byteenable[0];
	wire [7:0]  wd    = i_avs_writedata[7:0];
	wire        wr_cl = wr_go & (i_avs_address == `ADCSQ_IDX_CSL);
	wire        wr_ch = wr_go & (i_avs_address == `ADCSQ_IDX_CSH);
	wire        wr_rh = wr_go & (i_avs_address == `ADCSQ_IDX_RSH);

	// ********************************
	// triggers
	// ********************************
	// edge detectors reset to the idle pin levels
	wire ext_fall = ext_q & ~i_ext_trig_n;
	wire tmr_rise = ~tmr_q & i_timer_trig;
	wire sw_start = wr_ch & wd[`ADCSQ_B_START];
	wire trig     = sw_start
	              | (trg_q[0] & ext_fall)
	              | (trg_q[1] & tmr_rise);
	wire force_stop = wr_ch & ~wd[`ADCSQ_B_BUSY] & busy_q;
	wire done_clr   = (wr_ch & ~wd[`ADCSQ_B_DONE]) | i_xfer_clear;
	wire conv_end   = (state_q == ST_CMP) && (cnt_q == 13'h0000);

	// ********************************
	// sequencer next state
	// ********************************
	always @*
	begin
		state_d  = state_q;
		cnt_d    = cnt_q;
		cur_d    = cur_q;
		busy_d   = busy_q;
		result_d = result_q;
		store    = 1'b0;
		if (cnt_q != 13'h0000)
			cnt_d = cnt_q - 13'h0001;
		case (state_q)
			ST_IDLE:
			begin
				if (trig)
				begin
					state_d = ST_SMP;
					cur_d   = first_q;
					busy_d  = 1'b1;
					cnt_d   = smp_len(smp_q) - 13'h0001;
				end
			end
			ST_SMP:
			begin
				if (cnt_q == 13'h0000)
				begin
					state_d = ST_CMP;
					cnt_d   = cmp_len(cmp_q) - 13'h0001;
				end
			end
			ST_CMP:
			begin
				if (conv_end)
				begin
					if (i_xfer_enable & done_q & ~i_xfer_clear)
						state_d = ST_XWAIT;
					else
						store = 1'b1;
				end
			end
			ST_XWAIT:
			begin
				if (~done_q | i_xfer_clear)
					store = 1'b1;
			end
			ST_STOPW:
			begin
				if (trig)
				begin
					state_d = ST_SMP;
					cur_d   = next_chan(cur_q, last_q, first_q);
					cnt_d   = smp_len(smp_q) - 13'h0001;
				end
			end
			default:
			begin
				state_d = ST_IDLE;
				busy_d  = 1'b0;
			end
		endcase
		if (store)
		begin
			result_d = i_conv_data;
			cnt_d    = smp_len(smp_q) - 13'h0001;
			if (mode_q == `ADCSQ_MD_STOP)
				state_d = ST_STOPW;
			else if (mode_q == `ADCSQ_MD_CONT)
			begin
				state_d = ST_SMP;
				cur_d   = next_chan(cur_q, last_q, first_q);
			end
			else if (cur_q == last_q)
			begin
				state_d = ST_IDLE;
				busy_d  = 1'b0;
			end
			else
			begin
				state_d = ST_SMP;
				cur_d   = next_chan(cur_q, last_q, first_q);
			end
		end
		// retrigger in mode zero restarts from the first channel
		if (trig && busy_q && (mode_q == `ADCSQ_MD_SGL_RETRG) && !store)
		begin
			state_d = ST_SMP;
			cur_d   = first_q;
			cnt_d   = smp_len(smp_q) - 13'h0001;
		end
		if (force_stop)
		begin
			state_d = ST_IDLE;
			busy_d  = 1'b0;
		end
	end

	// a store in the same cycle as a clear leaves the flag set
	always @*
	begin
		done_d = done_q;
		if (done_clr)
			done_d = 1'b0;
		if (store)
			done_d = 1'b1;
	end

	// ********************************
	// read mux
	// ********************************
	always @*
	begin
		case (i_avs_address)
			`ADCSQ_IDX_CSL:
				rd_byte = {mode_q, busy_q ? cur_q : first_q, last_q};
			`ADCSQ_IDX_CSH:
				rd_byte = {busy_q, done_q, conv_irq_enable_q, state_q == ST_XWAIT,
				           trg_q, 1'b0, test_q};
			`ADCSQ_IDX_RSL:
				rd_byte = result_q[7:0];
			`ADCSQ_IDX_RSH:
				rd_byte = {5'h1F, 1'b0, result_q[9:8]};
			default:
				rd_byte = 8'h00;
		endcase
	end

	// ********************************
	// bus slave
	// ********************************
	// one wait state, then waitrequest low for a single cycle
	always @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata    <= 32'h00000000;
		end
		else
		begin
			o_avs_waitrequest <= ~(req & o_avs_waitrequest);
			if (req & o_avs_waitrequest)
				o_avs_readdata <= {24'h000000, rd_byte};
		end
	end

	// ********************************
	// control registers
	// ********************************
	always @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			conv_irq_enable_q  <= 1'b0;
			trg_q   <= `ADCSQ_RST_TRG;
			test_q  <= 1'b0;
			mode_q  <= `ADCSQ_RST_MODE;
			first_q <= `ADCSQ_RST_CHAN;
			last_q  <= `ADCSQ_RST_CHAN;
			smp_q   <= `ADCSQ_RST_SMP;
			cmp_q   <= `ADCSQ_RST_CMP;
		end
		else
		begin
			if (wr_ch)
			begin
				conv_irq_enable_q <= wd[`ADCSQ_B_CONV_IRQ_ENABLE];
				trg_q  <= wd[`ADCSQ_B_TRG_HI:`ADCSQ_B_TRG_LO];
				test_q <= wd[`ADCSQ_B_TEST];
			end
			if (wr_cl)
			begin
				mode_q  <= wd[7:6];
				first_q <= wd[5:3];
				last_q  <= wd[2:0];
			end
			if (wr_rh)
			begin
				smp_q <= wd[`ADCSQ_B_SMP_HI:`ADCSQ_B_SMP_LO];
				cmp_q <= wd[`ADCSQ_B_CMP_HI:`ADCSQ_B_CMP_LO];
			end
		end
	end

	// ********************************
	// sequencer registers and outputs
	// ********************************
	always @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			state_q    <= ST_IDLE;
			cnt_q      <= 13'h0000;
			cur_q      <= 3'h0;
			busy_q     <= 1'b0;
			done_q     <= 1'b0;
			result_q   <= 10'h000;
			ext_q      <= 1'b1;
			tmr_q      <= 1'b0;
			o_chan_sel <= 3'h0;
			o_sample   <= 1'b0;
			o_compare  <= 1'b0;
			o_busy     <= 1'b0;
			o_conv_irq <= 1'b0;
		end
		else
		begin
			state_q    <= state_d;
			cnt_q      <= cnt_d;
			cur_q      <= cur_d;
			busy_q     <= busy_d;
			done_q     <= done_d;
			result_q   <= result_d;
			ext_q      <= i_ext_trig_n;
			tmr_q      <= i_timer_trig;
			o_chan_sel <= cur_d;
			o_sample   <= (state_d == ST_SMP);
			o_compare  <= (state_d == ST_CMP);
			o_busy     <= busy_d;
			o_conv_irq <= done_d & conv_irq_enable_q;
		end
	end

endmodule

// >>> adcsq_defines.vh
`ifndef ADCSQ_DEFINES_VH
`define ADCSQ_DEFINES_VH

// register indices, byte address is four times the index
`define ADCSQ_IDX_CSL       8'h36
`define ADCSQ_IDX_CSH       8'h37
`define ADCSQ_IDX_RSL       8'h38
`define ADCSQ_IDX_RSH       8'h39

// control status high byte field positions
`define ADCSQ_B_BUSY        7
`define ADCSQ_B_DONE        6
`define ADCSQ_B_CONV_IRQ_ENABLE        5
`define ADCSQ_B_WAIT        4
`define ADCSQ_B_TRG_HI      3
`define ADCSQ_B_TRG_LO      2
`define ADCSQ_B_START       1
`define ADCSQ_B_TEST        0

// result high and timing byte field positions
`define ADCSQ_B_SMP_HI      6
`define ADCSQ_B_SMP_LO      5
`define ADCSQ_B_CMP_HI      4
`define ADCSQ_B_CMP_LO      3

// reset values
`define ADCSQ_RST_TRG       2'h0
`define ADCSQ_RST_MODE      2'h0
`define ADCSQ_RST_CHAN      3'h0
`define ADCSQ_RST_SMP       2'h0
`define ADCSQ_RST_CMP       2'h1

// mode codes
`define ADCSQ_MD_SGL_RETRG  2'h0
`define ADCSQ_MD_SGL        2'h1
`define ADCSQ_MD_CONT       2'h2
`define ADCSQ_MD_STOP       2'h3

// phase lengths in machine cycles
`define ADCSQ_SMP_SHORT     13'h0040
`define ADCSQ_SMP_LONG      13'h1000
`define ADCSQ_CMP_SHORT     13'h00B0
`define ADCSQ_CMP_LONG      13'h0160

`endif

// >>> adcsq_front.sv
`timescale 1ns/10ps
module adcsq_front
(
	input wire [2:0]   i_chan_sel,
	input wire         i_sample,
	output logic [9:0] o_conv_data
);
	// result held from compare end through any transfer wait
	assign o_conv_data = i_sample ? {~i_chan_sel, 7'h55} : {i_chan_sel, 7'h2A};
endmodule

// >>> adcsq_monitor.sv
`timescale 1ns/10ps
`include "adcsq_defines.vh"
module adcsq_monitor
#(
	parameter ADDR_W = 8
)
(
	input wire              i_clk_sys,
	input wire              i_nrst,
	input wire [ADDR_W-1:0] i_avs_address,
	input wire              i_avs_read,
	input wire              i_avs_write,
	input wire [31:0]       i_avs_writedata,
	input wire [3:0]        i_avs_byteenable,
	input wire              o_avs_waitrequest,
	input wire [2:0]        o_chan_sel,
	input wire              o_sample,
	input wire              o_compare,
	input wire              o_busy
);
	logic [12:0] smp_n_q;
	logic [12:0] cmp_n_q;
	logic        start_wr_q;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);
	// ***********************
	// phase length counters
	// ***********************
	always @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			smp_n_q    <= 13'h0000;
			cmp_n_q    <= 13'h0000;
			start_wr_q <= 1'b0;
		end
		else
		begin
			smp_n_q <= o_sample ? smp_n_q + 13'h0001 : 13'h0000;
			cmp_n_q <= o_compare ? cmp_n_q + 13'h0001 : 13'h0000;
			start_wr_q <= i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0]
			              && i_avs_address == 8'h37 && i_avs_writedata[1];
		end
	end
	// ***********************
	// properties
	// ***********************
	sequence s_csr_wr;
		i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0] && i_avs_address == 8'h37;
	endsequence
	property p_excl; !(o_sample && o_compare); endproperty
	property p_seq; o_busy && $fell(o_sample) |-> o_compare; endproperty
	property p_slen;
		o_busy && $fell(o_sample) |-> smp_n_q == `ADCSQ_SMP_SHORT || smp_n_q == `ADCSQ_SMP_LONG;
	endproperty
	property p_clen;
		o_busy && $fell(o_compare) && !start_wr_q |->
			cmp_n_q == `ADCSQ_CMP_SHORT || cmp_n_q == `ADCSQ_CMP_LONG;
	endproperty
	property p_ack; (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest; endproperty
	property p_one; !o_avs_waitrequest |=> o_avs_waitrequest; endproperty
	property p_start;
		s_csr_wr ##0 (i_avs_writedata[7] && i_avs_writedata[1] && !o_busy) |-> ##[1:2] o_busy && o_sample;
	endproperty
	property p_stop; s_csr_wr ##0 (!i_avs_writedata[7] && o_busy) |-> ##[1:2] !o_busy; endproperty
	property p_chan; o_busy && $changed(o_chan_sel) |-> $rose(o_sample); endproperty
	a_excl: assert property (p_excl) else $error("sample and compare overlap");
	a_seq: assert property (p_seq) else $error("compare did not follow sample");
	a_slen: assert property (p_slen) else $error("bad sample length");
	a_clen: assert property (p_clen) else $error("bad compare length");
	a_ack: assert property (p_ack) else $error("bus request not answered");
	a_one: assert property (p_one) else $error("waitrequest low too long");
	a_start: assert property (p_start) else $error("start write ignored");
	a_stop: assert property (p_stop) else $error("forced stop ignored");
	a_chan: assert property (p_chan) else $error("channel changed outside start");
endmodule

// >>> test_adc_sequencer_control.sv
`timescale 1ns/10ps
module test_adc_sequencer_control;
	logic i_clk_sys=0, i_nrst=0, i_avs_read=0, i_avs_write=0, i_ext_trig_n=1;
	logic i_timer_trig=0, i_xfer_enable=0, i_xfer_clear=0, smp_q=0;
	logic [7:0]  i_avs_address=8'h00;
	logic [7:0]  q;
	logic [31:0] i_avs_writedata=32'h0;
	logic [3:0]  i_avs_byteenable=4'hF;
	wire  [31:0] o_avs_readdata;
	wire  [9:0]  i_conv_data;
	wire  [2:0]  o_chan_sel;
	wire         o_avs_waitrequest, o_sample, o_compare, o_busy, o_conv_irq;
	logic [2:0]  chans[$];
	int          num_errors=0, samples_checked=0, i;
	adcsq_ctrl i_adcsq_ctrl(
		.i_clk_sys         (i_clk_sys),
		.i_nrst            (i_nrst),
		.i_avs_address     (i_avs_address),
		.i_avs_read        (i_avs_read),
		.i_avs_write       (i_avs_write),
		.i_avs_writedata   (i_avs_writedata),
		.i_avs_byteenable  (i_avs_byteenable),
		.o_avs_readdata    (o_avs_readdata),
		.o_avs_waitrequest (o_avs_waitrequest),
		.i_ext_trig_n      (i_ext_trig_n),
		.i_timer_trig      (i_timer_trig),
		.i_xfer_enable     (i_xfer_enable),
		.i_xfer_clear      (i_xfer_clear),
		.i_conv_data       (i_conv_data),
		.o_chan_sel        (o_chan_sel),
		.o_sample          (o_sample),
		.o_compare         (o_compare),
		.o_busy            (o_busy),
		.o_conv_irq        (o_conv_irq)
	);
	adcsq_front i_adcsq_front(.i_chan_sel(o_chan_sel), .i_sample(o_sample), .o_conv_data(i_conv_data));
	always #5 i_clk_sys = ~i_clk_sys;
	always @(negedge i_clk_sys)
	begin
		if (o_sample === 1'b1 && !smp_q) chans.push_back(o_chan_sel);
		smp_q = o_sample;
	end
	task automatic end_of_test;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
		samples_checked++;
		if (s !== e)
		begin
			$display("wrong value %s expected %h seen %h", nm, e, s);
			num_errors++;
		end
	endtask
	task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
		int n;
		n = 0;
		@(posedge i_clk_sys);
		i_avs_read <= !w;
		i_avs_write <= w;
		i_avs_address <= a;
		i_avs_writedata <= {24'h0, d};
		do begin @(posedge i_clk_sys); n++; end while (o_avs_waitrequest !== 1'b0 && n < 50);
		if (o_avs_waitrequest !== 1'b0) begin num_errors++; end_of_test; end
		q = o_avs_readdata[7:0];
		i_avs_read <= 0;
		i_avs_write <= 0;
	endtask
	task automatic wt(int k);
		int n;
		for (n = 0; n < 9000; n++)
		begin
			@(negedge i_clk_sys);
			if (k == -2 ? o_compare === 1'b1 : k < 0 ? o_busy === 1'b0 :
			    k == 0 ? o_conv_irq === 1'b1 : chans.size() >= k) break;
		end
		if (n >= 9000) begin num_errors++; end_of_test; end
	endtask
	task automatic irqc(logic [7:0] d, logic e);
		bus(1, 8'h37, d);
		repeat (2) @(negedge i_clk_sys);
		chk("irq", o_conv_irq, e);
	endtask
	task automatic conv(logic [7:0] cs);
		logic [2:0] c;
		int j;
		bus(1, 8'h36, cs);
		chans.delete();
		bus(1, 8'h37, 8'hA2);
		wt(-1);
		c = cs[5:3];
		for (j = 0; j < 8; j++)
		begin
			chk("chan", chans[j], c);
			if (c == cs[2:0]) break;
			c++;
		end
		chk("count", chans.size(), j + 1);
		bus(0, 8'h38, 0);
		chk("res_lo", q, {c[0], 7'h2A});
		bus(0, 8'h39, 0);
		chk("res_hi", q, {6'h3E, c[2:1]});
	endtask
	task automatic pulse_clear;
		@(posedge i_clk_sys) i_xfer_clear <= 1;
		@(posedge i_clk_sys) i_xfer_clear <= 0;
	endtask
	initial
	begin
		repeat (12) @(posedge i_clk_sys);
		i_nrst <= 1;
		bus(0, 8'h36, 0); chk("cs_lo", q, 0);
		bus(0, 8'h37, 0); chk("cs_hi", q, 0);
		bus(0, 8'h39, 0); chk("timing", q, 8'hF8);
		bus(0, 8'h20, 0); chk("unmapped", q, 0);
		$display("test reset done");
		conv(8'h79);
		bus(0, 8'h37, 0); chk("done", q, 8'h60);
		irqc(8'h40, 0);
		irqc(8'h60, 1);
		irqc(8'h20, 0);
		conv(8'h52);
		pulse_clear();
		bus(0, 8'h37, 0); chk("svc_clr", q, 8'h20);
		bus(1, 8'h39, 8'h68);
		conv(8'h52);
		bus(1, 8'h39, 8'h08);
		$display("test single done");
		bus(1, 8'h36, 8'h8A);
		chans.delete();
		bus(1, 8'h37, 8'hA2);
		wt(4);
		for (i = 0; i < 4; i++) chk("cont", chans[i], i[0] ? 2 : 1);
		chk("cont_busy", o_busy, 1);
		bus(1, 8'h37, 8'h60);
		@(negedge i_clk_sys);
		chk("stopped", {o_busy, o_sample, o_compare}, 3'b000);
		bus(1, 8'h36, 8'hDC);
		chans.delete();
		bus(1, 8'h37, 8'hA2);
		wt(0);
		repeat (3) @(negedge i_clk_sys);
		chk("pause", {o_busy, o_sample, o_compare}, 3'b100);
		bus(0, 8'h36, 0); chk("cur_chan", q, 8'hDC);
		bus(1, 8'h37, 8'hE2);
		wt(2);
		chk("next", chans[1], 4);
		bus(0, 8'h36, 0); chk("cur_chan2", q, 8'hE4);
		bus(1, 8'h37, 8'h60);
		for (i = 0; i < 2; i++)
		begin
			bus(1, 8'h36, {i[1:0], 6'h00});
			chans.delete();
			bus(1, 8'h37, 8'hA2);
			wt(-2);
			bus(1, 8'h37, 8'hE2);
			wt(-1);
			chk("retrig", chans.size(), 2 - i);
		end
		$display("test modes done");
		bus(1, 8'h36, 8'h52);
		for (i = 0; i < 4; i++)
		begin
			bus(1, 8'h37, {4'h2, i[1:0], 2'b00});
			@(posedge i_clk_sys) i_ext_trig_n <= 0;
			repeat (4) @(negedge i_clk_sys);
			chk("pin", o_busy, i[0]);
			@(posedge i_clk_sys) i_ext_trig_n <= 1;
			bus(1, 8'h37, {4'h6, i[1:0], 2'b00});
			@(posedge i_clk_sys) i_timer_trig <= 1;
			repeat (4) @(negedge i_clk_sys);
			chk("timer", o_busy, i[1]);
			@(posedge i_clk_sys) i_timer_trig <= 0;
			bus(1, 8'h37, 8'h60);
		end
		$display("test triggers done");
		i_xfer_enable <= 1;
		bus(1, 8'h36, 8'h92);
		bus(1, 8'h37, 8'hA2);
		wt(0);
		repeat (500) @(negedge i_clk_sys);
		bus(0, 8'h37, 0); chk("wait", q, 8'hF0);
		pulse_clear();
		bus(0, 8'h37, 0); chk("resume", q, 8'hE0);
		bus(1, 8'h37, 8'h60);
		$display("test transfer done");
		end_of_test;
	end
endmodule
bind adcsq_ctrl adcsq_monitor #(.ADDR_W(ADDR_W)) i_adcsq_monitor(
	.i_clk_sys         (i_clk_sys),
	.i_nrst            (i_nrst),
	.i_avs_address     (i_avs_address),
	.i_avs_read        (i_avs_read),
	.i_avs_write       (i_avs_write),
	.i_avs_writedata   (i_avs_writedata),
	.i_avs_byteenable  (i_avs_byteenable),
	.o_avs_waitrequest (o_avs_waitrequest),
	.o_chan_sel        (o_chan_sel),
	.o_sample          (o_sample),
	.o_compare         (o_compare),
	.o_busy            (o_busy)
);
